/* File: verilog/trigger_step_sequencer_map.svh */
// constants of the trigger step sequencer
`ifndef TRIGGER_STEP_SEQUENCER_MAP_SVH
`define TRIGGER_STEP_SEQUENCER_MAP_SVH
`define TSS_CODE_MSB 7
`define TSS_CODE_LSB 4
`define TSS_OPT_MSB 3
`define TSS_OPT_LSB 0
`define TSS_COPY_SEL_BIT 3
`define TSS_CODE_CONTROL 4'h0
`define TSS_CODE_ADD_COPY 4'h1
`define TSS_CODE3_STROBE 3'h1
`define TSS_CODE_WAIT_RISE 4'h4
`define TSS_CODE_WAIT_FALL 4'h5
`define TSS_CODE_IRQ 4'h7
`define TSS_CODE3_TRIG 3'h4
`define TSS_CODE3_JUMP 3'h5
`define TSS_CODE3_LOOP_ZERO 3'h6
`define TSS_CODE3_LOOP_ONE 3'h7
`define TSS_CTRL_NOP 4'h0
`define TSS_CTRL_CLEAR_LOOPS 4'h1
`define TSS_CTRL_HALT 4'h2
`define TSS_TGT_LIMIT_ZERO 3'h0
`define TSS_TGT_LIMIT_ONE 3'h1
`define TSS_CFG_ADJUST 2'h0
`define TSS_CFG_HOLD 2'h1
`define TSS_CFG_LIMIT_ZERO 2'h2
`define TSS_CFG_LIMIT_ONE 2'h3
`define TSS_RST_PTR 5'h00
`define TSS_RST_VALUE 16'h0000
`define TSS_RST_ADC_SEL 5'h00
`endif

/* File: verilog/trigger_step_sequencer_pkg.sv */
// types of the trigger step sequencer
package trigger_step_sequencer_pkg;
    typedef logic [7:0] step_t;
    typedef logic [4:0] qaddr_t;
    typedef logic [15:0] value_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_EXEC = 3'b010,
        ST_WAIT = 3'b100
    } seq_state_t;
endpackage

/* File: verilog/trigger_step_sequencer.sv */
// step-command sequencer of the trigger generator
`timescale 1ns/10ps
`default_nettype none
`include "trigger_step_sequencer_map.svh"

module trigger_step_sequencer
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // run control
    input wire logic startPulse,
    input wire logic stopPulse,
    // queue load
    input wire logic queueWrEn,
    input wire trigger_step_sequencer_pkg::qaddr_t queueWrAddr,
    input wire trigger_step_sequencer_pkg::step_t queueWrData,
    // settings load
    input wire logic cfgWrEn,
    input wire logic [1:0] cfgSel,
    input wire trigger_step_sequencer_pkg::value_t cfgData,
    // trigger inputs
    input wire logic [15:0] trigIn,
    // outputs to peripherals
    output logic [4:0] adcPositiveInputSelect,
    output logic [15:0] irqRequest,
    output logic [31:0] trigOut,
    // status
    output logic busy,
    output logic waiting,
    output trigger_step_sequencer_pkg::qaddr_t queuePointer,
    output trigger_step_sequencer_pkg::value_t loopCounterZero,
    output trigger_step_sequencer_pkg::value_t loopCounterOne,
    output trigger_step_sequencer_pkg::value_t loopLimitZero,
    output trigger_step_sequencer_pkg::value_t loopLimitOne
);
    import trigger_step_sequencer_pkg::*;

    // 32 steps, written by software only, read asynchronously
    step_t queueMem [0:31];

    seq_state_t state_reg, state_next;
    qaddr_t ptr_reg, ptr_next;
    value_t cnt0_reg, cnt0_next, cnt1_reg, cnt1_next;
    value_t lim0_reg, lim0_next, lim1_reg, lim1_next;
    value_t adjust_value_reg, adjust_value_next;
    value_t hold_value_reg, hold_value_next;
    logic [4:0] adcSel_reg, adcSel_next;
    logic [15:0] irq_reg, irq_next;
    logic [31:0] trig_reg, trig_next;
    logic [15:0] trigPrev_reg;
    step_t curCmd;
    logic [3:0] code;
    logic [3:0] opt;
    logic riseSeen;
    logic fallSeen;
    logic busy_reg, busy_next;
    logic waiting_reg, waiting_next;

    // the low code bit joined to the option field, shared by several steps
    function automatic qaddr_t lowField(input step_t c);
        lowField = {c[`TSS_CODE_LSB], c[`TSS_OPT_MSB:`TSS_OPT_LSB]};
    endfunction

    function automatic qaddr_t nextPtr(input qaddr_t p);
        nextPtr = p + 5'h01;
    endfunction

    always_ff @(posedge ref_clk)
    begin
        if (queueWrEn)
        begin
            queueMem[queueWrAddr] <= queueWrData;
        end
    end

    assign curCmd = queueMem[ptr_reg];
    assign code = curCmd[`TSS_CODE_MSB:`TSS_CODE_LSB];
    assign opt = curCmd[`TSS_OPT_MSB:`TSS_OPT_LSB];
    // edges are judged against last cycle's sample, so a pulse of one cycle still counts
    assign riseSeen = trigIn[opt] & ~trigPrev_reg[opt];
    assign fallSeen = ~trigIn[opt] & trigPrev_reg[opt];

    always_comb
    begin
        state_next = state_reg;
        ptr_next = ptr_reg;
        cnt0_next = cnt0_reg;
        cnt1_next = cnt1_reg;
        lim0_next = lim0_reg;
        lim1_next = lim1_reg;
        adjust_value_next = adjust_value_reg;
        hold_value_next = hold_value_reg;
        adcSel_next = adcSel_reg;
        irq_next = 16'h0000;
        trig_next = 32'h00000000;
        if (cfgWrEn)
        begin
            unique case (cfgSel)
                `TSS_CFG_ADJUST: adjust_value_next = cfgData;
                `TSS_CFG_HOLD: hold_value_next = cfgData;
                `TSS_CFG_LIMIT_ZERO: lim0_next = cfgData;
                `TSS_CFG_LIMIT_ONE: lim1_next = cfgData;
            endcase
        end
        unique case (state_reg)
            ST_IDLE:
            begin
                if (startPulse)
                begin
                    state_next = ST_EXEC;
                    ptr_next = `TSS_RST_PTR;
                    cnt0_next = `TSS_RST_VALUE;
                    cnt1_next = `TSS_RST_VALUE;
                end
            end
            ST_EXEC:
            begin
                ptr_next = nextPtr(ptr_reg);
                if (code == `TSS_CODE_CONTROL)
                begin
                    if (opt == `TSS_CTRL_CLEAR_LOOPS)
                    begin
                        cnt0_next = `TSS_RST_VALUE;
                        cnt1_next = `TSS_RST_VALUE;
                    end
                    else if (opt == `TSS_CTRL_HALT)
                    begin
                        state_next = ST_IDLE;
                    end
                end
                else if (code == `TSS_CODE_ADD_COPY)
                begin
                    // a step write wins over a software write to the same limit
                    if (opt[2:0] == `TSS_TGT_LIMIT_ZERO)
                    begin
                        lim0_next = opt[`TSS_COPY_SEL_BIT] ? hold_value_reg
                            : lim0_reg + adjust_value_reg;
                    end
                    else if (opt[2:0] == `TSS_TGT_LIMIT_ONE)
                    begin
                        lim1_next = opt[`TSS_COPY_SEL_BIT] ? hold_value_reg
                            : lim1_reg + adjust_value_reg;
                    end
                end
                else if (code[3:1] == `TSS_CODE3_STROBE)
                begin
                    adcSel_next = lowField(curCmd);
                end
                else if (code == `TSS_CODE_WAIT_RISE || code == `TSS_CODE_WAIT_FALL)
                begin
                    ptr_next = ptr_reg;
                    state_next = ST_WAIT;
                end
                else if (code == `TSS_CODE_IRQ)
                begin
                    irq_next[opt] = 1'b1;
                end
                else if (code[3:1] == `TSS_CODE3_TRIG)
                begin
                    trig_next[lowField(curCmd)] = 1'b1;
                end
                else if (code[3:1] == `TSS_CODE3_JUMP)
                begin
                    ptr_next = lowField(curCmd);
                end
                else if (code[3:1] == `TSS_CODE3_LOOP_ZERO && cnt0_reg != lim0_reg)
                begin
                    cnt0_next = cnt0_reg + 16'h0001;
                    ptr_next = lowField(curCmd);
                end
                else if (code[3:1] == `TSS_CODE3_LOOP_ONE && cnt1_reg != lim1_reg)
                begin
                    cnt1_next = cnt1_reg + 16'h0001;
                    ptr_next = lowField(curCmd);
                end
                // code 0110 and unknown options fall through as a plain advance
            end
            ST_WAIT:
            begin
                if ((code == `TSS_CODE_WAIT_RISE) ? riseSeen : fallSeen)
                begin
                    ptr_next = nextPtr(ptr_reg);
                    state_next = ST_EXEC;
                end
            end
        endcase
        // stop wins over any step in flight
        if (stopPulse)
        begin
            state_next = ST_IDLE;
        end
        // status comes from the next state so both flags leave a flop with no decode
        busy_next = (state_next != ST_IDLE);
        waiting_next = (state_next == ST_WAIT);
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            state_reg <= ST_IDLE;
            ptr_reg <= `TSS_RST_PTR;
            cnt0_reg <= `TSS_RST_VALUE;
            cnt1_reg <= `TSS_RST_VALUE;
            lim0_reg <= `TSS_RST_VALUE;
            lim1_reg <= `TSS_RST_VALUE;
            adjust_value_reg <= `TSS_RST_VALUE;
            hold_value_reg <= `TSS_RST_VALUE;
            adcSel_reg <= `TSS_RST_ADC_SEL;
            irq_reg <= 16'h0000;
            trig_reg <= 32'h00000000;
            trigPrev_reg <= 16'h0000;
            busy_reg <= 1'b0;
            waiting_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            ptr_reg <= ptr_next;
            cnt0_reg <= cnt0_next;
            cnt1_reg <= cnt1_next;
            lim0_reg <= lim0_next;
            lim1_reg <= lim1_next;
            adjust_value_reg <= adjust_value_next;
            hold_value_reg <= hold_value_next;
            adcSel_reg <= adcSel_next;
            irq_reg <= irq_next;
            trig_reg <= trig_next;
            trigPrev_reg <= trigIn;
            busy_reg <= busy_next;
            waiting_reg <= waiting_next;
        end
    end

    assign adcPositiveInputSelect = adcSel_reg;
    assign irqRequest = irq_reg;
    assign trigOut = trig_reg;
    assign busy = busy_reg;
    assign waiting = waiting_reg;
    assign queuePointer = ptr_reg;
    assign loopCounterZero = cnt0_reg;
    assign loopCounterOne = cnt1_reg;
    assign loopLimitZero = lim0_reg;
    assign loopLimitOne = lim1_reg;

    logic execNow;
    assign execNow = (state_reg == ST_EXEC) && !stopPulse;

    a_halt_control: assert property (@(posedge ref_clk) disable iff (!rstn)
        execNow && code == `TSS_CODE_CONTROL && opt == `TSS_CTRL_HALT |=> state_reg == ST_IDLE)
        else $error("halt step did not stop the sequencer");
    a_add_limit: assert property (@(posedge ref_clk) disable iff (!rstn)
        execNow && curCmd == 8'h10 |=> lim0_reg == $past(lim0_reg) + $past(adjust_value_reg))
        else $error("add step result wrong");
    a_copy_limit: assert property (@(posedge ref_clk) disable iff (!rstn)
        execNow && curCmd == 8'h19 |=> lim1_reg == $past(hold_value_reg))
        else $error("copy step result wrong");
    a_adc_select: assert property (@(posedge ref_clk) disable iff (!rstn)
        execNow && code[3:1] == 3'h1 |=> adcPositiveInputSelect == $past(curCmd[4:0]))
        else $error("adc select not loaded");
    a_wait_holds: assert property (@(posedge ref_clk) disable iff (!rstn)
        waiting && code == 4'h4 && !riseSeen && !stopPulse |=> waiting && $stable(queuePointer))
        else $error("rise wait left without an edge");
    a_wait_fall_done: assert property (@(posedge ref_clk) disable iff (!rstn)
        waiting && code == 4'h5 && fallSeen && !stopPulse
        |=> queuePointer == $past(queuePointer) + 5'h01 && state_reg == ST_EXEC)
        else $error("fall wait did not advance");
    a_irq_pulse: assert property (@(posedge ref_clk) disable iff (!rstn)
        execNow && code == 4'h7 |=> irqRequest == (16'h0001 << $past(opt)) ##1 irqRequest == 16'h0000
        || execNow)
        else $error("interrupt request wrong");
    a_trig_onehot: assert property (@(posedge ref_clk) disable iff (!rstn)
        execNow && code[3:1] == 3'h4 |=> trigOut == (32'h00000001 << $past(curCmd[4:0])))
        else $error("trigger output wrong");
    a_jump_target: assert property (@(posedge ref_clk) disable iff (!rstn)
        execNow && code[3:1] == 3'h5 |=> queuePointer == $past(curCmd[4:0]))
        else $error("jump target wrong");
    a_loop_zero: assert property (@(posedge ref_clk) disable iff (!rstn)
        execNow && code[3:1] == 3'h6 && cnt0_reg == lim0_reg
        |=> queuePointer == $past(queuePointer) + 5'h01 && $stable(loopCounterZero))
        else $error("loop zero exit wrong");
    a_loop_one: assert property (@(posedge ref_clk) disable iff (!rstn)
        execNow && code[3:1] == 3'h7 && cnt1_reg != lim1_reg
        |=> loopCounterOne == $past(loopCounterOne) + 16'h0001)
        else $error("loop one count wrong");
    a_reserved_nop: assert property (@(posedge ref_clk) disable iff (!rstn)
        execNow && code == 4'h6 |=> queuePointer == $past(queuePointer) + 5'h01
        && $stable(adcPositiveInputSelect) && trigOut == 32'h00000000)
        else $error("reserved step had an effect");
endmodule
`default_nettype wire

/* File: sim/trigger_source_model.sv */
// trigger source model driving the sequencer's trigger inputs
`timescale 1ns/10ps
`default_nettype none
module trigger_source_model
(
    // clock
    input wire logic ref_clk,
    // level change request
    input wire logic setEn,
    input wire logic [3:0] setIdx,
    input wire logic setVal,
    // trigger lines
    output logic [15:0] trigIn
);
    // registered so every level lasts at least one whole cycle
    initial trigIn = 16'h0000;
    always @(posedge ref_clk)
    begin
        if (setEn)
        begin
            trigIn[setIdx] <= setVal;
        end
    end
endmodule
`default_nettype wire

/* File: sim/trigger_step_sequencer_test.sv */
// self-checking bench of the trigger step sequencer
`timescale 1ns/10ps
`default_nettype none
module trigger_step_sequencer_test;
    import trigger_step_sequencer_pkg::*;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic startPulse = 1'b0;
    logic stopPulse = 1'b0;
    logic queueWrEn = 1'b0;
    qaddr_t queueWrAddr = 5'h00;
    step_t queueWrData = 8'h00;
    logic cfgWrEn = 1'b0;
    logic [1:0] cfgSel = 2'h0;
    value_t cfgData = 16'h0000;
    logic setEn = 1'b0;
    logic [3:0] setIdx = 4'h0;
    logic setVal = 1'b0;
    logic [15:0] trigIn;
    logic [4:0] adcSel;
    logic [15:0] irqRequest;
    logic [31:0] trigOut;
    logic busy;
    logic waiting;
    qaddr_t queuePointer;
    value_t cnt0;
    value_t cnt1;
    value_t lim0;
    value_t lim1;
    int errTotal = 0;
    int numChecks = 0;
    int cycles = 0;
    int i;
    int r;
    int p;
    step_t prog [12];
    logic [4:0] expAdc;
    logic [31:0] orTrig;
    value_t a;
    value_t h;
    value_t l;
    trigger_step_sequencer uut (.ref_clk(ref_clk), .rstn(rstn), .startPulse(startPulse),
        .stopPulse(stopPulse), .queueWrEn(queueWrEn), .queueWrAddr(queueWrAddr),
        .queueWrData(queueWrData), .cfgWrEn(cfgWrEn), .cfgSel(cfgSel), .cfgData(cfgData),
        .trigIn(trigIn), .adcPositiveInputSelect(adcSel), .irqRequest(irqRequest),
        .trigOut(trigOut), .busy(busy), .waiting(waiting), .queuePointer(queuePointer),
        .loopCounterZero(cnt0), .loopCounterOne(cnt1), .loopLimitZero(lim0),
        .loopLimitOne(lim1));
    trigger_source_model src (.ref_clk(ref_clk), .setEn(setEn), .setIdx(setIdx),
        .setVal(setVal), .trigIn(trigIn));
    always #20 ref_clk = ~ref_clk;
    task automatic conclude;
        $display("checks %0d mismatches %0d", numChecks, errTotal);
        if (errTotal == 0 && numChecks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // a hung wait step must not stall the run forever
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errTotal++;
            conclude();
        end
    end
    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        numChecks++;
        if (seen !== exp)
        begin
            errTotal++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick;
        @(posedge ref_clk);
        #1;
    endtask
    task automatic put(int addr, step_t d);
        @(posedge ref_clk);
        queueWrEn <= 1'b1;
        queueWrAddr <= 5'(addr);
        queueWrData <= d;
    endtask
    task automatic cfg(logic [1:0] sel, value_t d);
        @(posedge ref_clk);
        cfgWrEn <= 1'b1;
        cfgSel <= sel;
        cfgData <= d;
    endtask
    task automatic start;
        @(posedge ref_clk);
        queueWrEn <= 1'b0;
        cfgWrEn <= 1'b0;
        startPulse <= 1'b1;
        @(posedge ref_clk);
        startPulse <= 1'b0;
        #1;
        chk("busy", busy, 1);
    endtask
    task automatic level(int idx, logic v);
        @(posedge ref_clk);
        setEn <= 1'b1;
        setIdx <= 4'(idx);
        setVal <= v;
        @(posedge ref_clk);
        setEn <= 1'b0;
        #1;
    endtask
    task automatic run_out;
        p = 0;
        orTrig = 32'h0;
        for (int k = 0; k < 64 && busy === 1'b1; k++)
        begin
            tick();
            orTrig = orTrig | trigOut;
            if (trigOut[0] === 1'b1)
                p++;
        end
        chk("busy", busy, 0);
    endtask
    // reserved code 0110 and control options other than halt must leave the outputs and the pointer as a nop does
    function automatic step_t rand_step;
        logic [4:0] v;
        v = 5'($urandom);
        case ($urandom % 5)
            0: rand_step = {3'h4, v};
            1: rand_step = {4'h7, v[3:0]};
            2: rand_step = {3'h1, v};
            3: rand_step = {4'h6, v[3:0]};
            default: rand_step = {4'h0, (v[3:0] == 4'h2) ? 4'h3 : v[3:0]};
        endcase
    endfunction
    function automatic logic [31:0] trig_exp(step_t s);
        trig_exp = (s[7:5] == 3'h4) ? 32'h1 << s[4:0] : 32'h0;
    endfunction
    function automatic logic [15:0] irq_exp(step_t s);
        irq_exp = (s[7:4] == 4'h7) ? 16'h1 << s[3:0] : 16'h0;
    endfunction
    initial
    begin
        void'($urandom(2));
        repeat (10) @(posedge ref_clk);
        rstn <= 1'b1;
        tick();
        chk("busy", busy, 0);
        expAdc = 5'h00;
        for (r = 0; r < 4; r++)
        begin
            for (i = 0; i < 12; i++)
            begin
                prog[i] = rand_step();
                put(i, prog[i]);
            end
            put(12, 8'h02);
            start();
            for (i = 0; i < 12; i++)
            begin
                tick();
                if (prog[i][7:5] == 3'h1)
                    expAdc = prog[i][4:0];
                chk("trigOut", trigOut, trig_exp(prog[i]));
                chk("irqRequest", irqRequest, 32'(irq_exp(prog[i])));
                chk("adcSelect", adcSel, 32'(expAdc));
                chk("queuePointer", queuePointer, i + 1);
            end
            run_out();
            chk("haltPointer", queuePointer, 13);
        end
        a = 16'($urandom);
        h = 16'($urandom);
        l = 16'($urandom);
        cfg(2'h0, a);
        cfg(2'h1, h);
        cfg(2'h2, l);
        put(0, 8'h10);
        put(1, 8'h19);
        put(2, 8'h11);
        put(3, 8'h1d);
        put(4, 8'h02);
        start();
        run_out();
        chk("limitZero", lim0, 32'(value_t'(l + a)));
        chk("limitOne", lim1, 32'(value_t'(h + a)));
        l = 16'(1 + $urandom % 5);
        cfg(2'h2, l);
        cfg(2'h3, 16'h0001);
        put(0, 8'h80);
        put(1, 8'hc0);
        put(2, 8'ha4);
        put(3, 8'h8f);
        put(4, 8'he4);
        put(5, 8'h02);
        start();
        run_out();
        chk("loopPulses", p, l + 1);
        chk("counterZero", cnt0, 32'(l));
        chk("counterOne", cnt1, 1);
        chk("skippedTrig", orTrig, 32'h1);
        chk("endPointer", queuePointer, 6);
        put(0, 8'hc2);
        put(1, 8'h02);
        put(2, 8'h01);
        put(3, 8'h02);
        start();
        run_out();
        chk("clearedCounter", cnt0, 0);
        chk("clearPointer", queuePointer, 4);
        put(0, 8'h43);
        put(1, 8'h53);
        put(2, 8'h02);
        start();
        level(4, 1'b1);
        tick();
        chk("waiting", waiting, 1);
        chk("waitPointer", queuePointer, 0);
        level(3, 1'b1);
        tick();
        chk("risePointer", queuePointer, 1);
        level(4, 1'b0);
        tick();
        chk("fallWaitPointer", queuePointer, 1);
        level(3, 1'b0);
        tick();
        chk("fallPointer", queuePointer, 2);
        run_out();
        put(0, 8'h4a);
        start();
        repeat (3) tick();
        @(posedge ref_clk);
        stopPulse <= 1'b1;
        @(posedge ref_clk);
        stopPulse <= 1'b0;
        #1;
        chk("stopBusy", busy, 0);
        chk("stopPointer", queuePointer, 0);
        conclude();
    end
endmodule
`default_nettype wire
